// File: verilog/ecpd_top.sv
// error counter clear and encoder pulse divider, top level
// assumes: configuration and reference steps come from logic on CLK_SYS;
// encoder and clear pins are asynchronous
//
// Notes on behaviour
// - clearing condition forces the position error counter to zero.
// - clearing condition suspends position loop control.
// - clear form selector resets to level-high clearing.
// - form 0 holds the counter cleared while clear input is high.
// - form 1 clears once on each rising edge of clear input.
// - form 2 holds the counter cleared while clear input is low.
// - form 3 clears once on each falling edge of clear input.
// - divided encoder pulses drive differential phase A and B outputs; C repeats the synchronised index undivided.
// - divider sets output pulses per revolution; up to 65535, default 2048.
// - with a 13-bit encoder the divider is capped at 2048 pulses per rev.
// - divider zero passes encoder pulses one for one.
// - quadrature source gives divider times lines times 4 over 65536.
// - divider setting is latched once, on the first clock after each reset.
// - divider is independent of the electronic gear settings.
`include "ecpd_regs.svh"
module ecpd_top (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // configuration
  input wire logic [1:0] CLEAR_FORM_SELECT,
  input wire logic [15:0] OUTPUT_PULSE_DIVIDER,
  input wire logic [15:0] SOURCE_ENCODER_LINE_COUNT,
  input wire logic ENCODER_IS_SERIAL,
  input wire logic ENCODER_13BIT,
  // clear pin
  input wire logic COUNTER_CLEAR_INPUT,
  // motor encoder pins
  input wire logic ENC_PHASE_A,
  input wire logic ENC_PHASE_B,
  input wire logic ENC_PHASE_Z,
  // reference steps after gearing
  input wire logic REF_STEP,
  input wire logic REF_DIR_UP,
  // position loop
  output logic [19:0] POSITION_ERROR,
  output logic POSITION_LOOP_ENABLE,
  output logic ENCODER_FAULT,
  // divided encoder outputs
  output logic DIVIDED_PHASE_A_OUT,
  output logic DIVIDED_PHASE_A_OUT_N,
  output logic DIVIDED_PHASE_B_OUT,
  output logic DIVIDED_PHASE_B_OUT_N,
  output logic DIVIDED_INDEX_OUT,
  output logic DIVIDED_INDEX_OUT_N
);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [3:0] pins_sync;

  ecpd_sync #(
    .W(4)
  ) u_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .d({COUNTER_CLEAR_INPUT, ENC_PHASE_A, ENC_PHASE_B, ENC_PHASE_Z}),
    .q(pins_sync)
  );

  wire clr_s = pins_sync[3];
  wire enc_a = pins_sync[2];
  wire enc_b = pins_sync[1];
  wire enc_z = pins_sync[0];

  //////////////////////////////////////////////////////////////////////////
  // clear qualifier

  logic clearing;

  ecpd_clear_ctl u_clear (
    .clk(CLK_SYS),
    .rst(RST),
    .clr_level(clr_s),
    .form_sel(CLEAR_FORM_SELECT),
    .clearing(clearing)
  );

  //////////////////////////////////////////////////////////////////////////
  // power-up latch of divider settings

  logic cfg_done_ff;
  logic [15:0] div_lat_ff;
  logic [15:0] lines_lat_ff;
  logic serial_lat_ff;
  logic enc13_lat_ff;

  // later changes are ignored until the next reset
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      cfg_done_ff <= 1'b0;
      div_lat_ff <= `ECPD_DIV_RESET;
      lines_lat_ff <= `ECPD_LINES_RESET;
      serial_lat_ff <= 1'b0;
      enc13_lat_ff <= 1'b0;
    end
    else if (!cfg_done_ff)
    begin
      cfg_done_ff <= 1'b1;
      div_lat_ff <= OUTPUT_PULSE_DIVIDER;
      lines_lat_ff <= SOURCE_ENCODER_LINE_COUNT;
      serial_lat_ff <= ENCODER_IS_SERIAL;
      enc13_lat_ff <= ENCODER_13BIT;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // quadrature decoder of the motor encoder

  logic a_prev_ff;
  logic b_prev_ff;
  logic [2:0] primed_ff;
  logic fault_ff;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      a_prev_ff <= 1'b0;
      b_prev_ff <= 1'b0;
      primed_ff <= 3'h0;
    end
    else
    begin
      a_prev_ff <= enc_a;
      b_prev_ff <= enc_b;
      primed_ff <= {primed_ff[1:0], 1'b1};
    end
  end

  // no decoding until synchroniser and history hold real pin levels
  wire primed = primed_ff[2];
  wire a_chg = enc_a ^ a_prev_ff;
  wire b_chg = enc_b ^ b_prev_ff;
  wire one_chg = primed & (a_chg ^ b_chg);
  wire both_chg = primed & a_chg & b_chg;
  wire enc_fwd = enc_a ^ b_prev_ff;
  wire cnt_up = one_chg & enc_fwd;
  wire cnt_dn = one_chg & ~enc_fwd;

  // both phases moving at once is a lost count; sticky until reset
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      fault_ff <= 1'b0;
    else if (both_chg)
      fault_ff <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // position error counter

  logic [19:0] err_ff;
  logic [19:0] nxt_err;
  logic loop_en_ff;

  wire ref_up = REF_STEP & REF_DIR_UP;
  wire ref_dn = REF_STEP & ~REF_DIR_UP;
  wire [19:0] ref_term = ref_up ? `ECPD_ERR_PLUS1 :
                         ref_dn ? `ECPD_ERR_MINUS1 : `ECPD_ERR_ZERO;
  wire [19:0] fb_term = cnt_up ? `ECPD_ERR_PLUS1 :
                        cnt_dn ? `ECPD_ERR_MINUS1 : `ECPD_ERR_ZERO;
  wire [19:0] err_sum = err_ff + ref_term - fb_term;

  assign nxt_err = clearing ? `ECPD_ERR_ZERO : err_sum;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      err_ff <= `ECPD_ERR_RESET;
      loop_en_ff <= 1'b0;
    end
    else
    begin
      err_ff <= nxt_err;
      loop_en_ff <= ~clearing;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // fractional divider; uses no gear numerator or denominator

  wire div_over13 = enc13_lat_ff & (div_lat_ff > `ECPD_ENC13_PPR_CAP);
  wire [15:0] div_cap13 = div_over13 ? `ECPD_ENC13_PPR_CAP : div_lat_ff;
  wire div_over_lines = serial_lat_ff & (div_cap13 > lines_lat_ff);
  wire [15:0] div_eff = div_over_lines ? lines_lat_ff : div_cap13;
  wire pass = (div_eff == `ECPD_DIV_PASS);

  // serial: div_eff pulses per rev; quadrature: scaled by 65536
  wire [16:0] modulus = serial_lat_ff ? {1'b0, lines_lat_ff} :
                        `ECPD_QUAD_MODULUS;

  logic [16:0] acc_ff;
  logic [16:0] nxt_acc;

  wire [17:0] inc18 = {2'b00, div_eff};
  wire [17:0] mod18 = {1'b0, modulus};
  wire [17:0] sum_up = {1'b0, acc_ff} + inc18;
  wire up_wrap = (sum_up >= mod18);
  wire [17:0] sum_up_wr = sum_up - mod18;
  wire [16:0] acc_up = up_wrap ? sum_up_wr[16:0] : sum_up[16:0];
  wire dn_wrap = ({1'b0, acc_ff} < inc18);
  wire [17:0] sum_dn_wr = {1'b0, acc_ff} + mod18 - inc18;
  wire [17:0] sum_dn = {1'b0, acc_ff} - inc18;
  wire [16:0] acc_dn = dn_wrap ? sum_dn_wr[16:0] : sum_dn[16:0];

  wire step_up = cfg_done_ff & cnt_up;
  wire step_dn = cfg_done_ff & cnt_dn;
  wire out_up = step_up & (pass | up_wrap);
  wire out_dn = step_dn & (pass | dn_wrap);

  assign nxt_acc = pass ? acc_ff :
                   step_up ? acc_up :
                   step_dn ? acc_dn : acc_ff;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      acc_ff <= 17'h00000;
    else
      acc_ff <= nxt_acc;
  end

  //////////////////////////////////////////////////////////////////////////
  // output quadrature generator

  ecpd_pkg::ecpd_phase_t ph_ff;
  ecpd_pkg::ecpd_phase_t nxt_ph;

  // forward walks 00,10,11,01 so A leads B
  always_comb
  begin
    nxt_ph = ph_ff;
    case (ph_ff)
      ecpd_pkg::ECPD_PH_00:
      begin
        if (out_up)
          nxt_ph = ecpd_pkg::ECPD_PH_10;
        else if (out_dn)
          nxt_ph = ecpd_pkg::ECPD_PH_01;
      end
      ecpd_pkg::ECPD_PH_10:
      begin
        if (out_up)
          nxt_ph = ecpd_pkg::ECPD_PH_11;
        else if (out_dn)
          nxt_ph = ecpd_pkg::ECPD_PH_00;
      end
      ecpd_pkg::ECPD_PH_11:
      begin
        if (out_up)
          nxt_ph = ecpd_pkg::ECPD_PH_01;
        else if (out_dn)
          nxt_ph = ecpd_pkg::ECPD_PH_10;
      end
      ecpd_pkg::ECPD_PH_01:
      begin
        if (out_up)
          nxt_ph = ecpd_pkg::ECPD_PH_00;
        else if (out_dn)
          nxt_ph = ecpd_pkg::ECPD_PH_11;
      end
      default:
        nxt_ph = ecpd_pkg::ECPD_PH_00;
    endcase
  end

  wire nxt_a = (nxt_ph == ecpd_pkg::ECPD_PH_10) |
               (nxt_ph == ecpd_pkg::ECPD_PH_11);
  wire nxt_b = (nxt_ph == ecpd_pkg::ECPD_PH_11) |
               (nxt_ph == ecpd_pkg::ECPD_PH_01);

  logic [5:0] out_ff;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      ph_ff <= ecpd_pkg::ECPD_PH_00;
      out_ff <= 6'h15;
    end
    else
    begin
      ph_ff <= nxt_ph;
      // true and complement of each pair
      out_ff <= {nxt_a, ~nxt_a, nxt_b, ~nxt_b, enc_z, ~enc_z};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign POSITION_ERROR = err_ff;
  assign POSITION_LOOP_ENABLE = loop_en_ff;
  assign ENCODER_FAULT = fault_ff;
  assign DIVIDED_PHASE_A_OUT = out_ff[5];
  assign DIVIDED_PHASE_A_OUT_N = out_ff[4];
  assign DIVIDED_PHASE_B_OUT = out_ff[3];
  assign DIVIDED_PHASE_B_OUT_N = out_ff[2];
  assign DIVIDED_INDEX_OUT = out_ff[1];
  assign DIVIDED_INDEX_OUT_N = out_ff[0];

endmodule

// File: include/ecpd_regs.svh
// constants for the error clear and pulse divider block
// assumes: included by bare name from the design files
`ifndef ECPD_REGS_SVH
`define ECPD_REGS_SVH

// widths
`define ECPD_DIV_W 16
`define ECPD_MOD_W 17
`define ECPD_ERR_W 20

// reset values
`define ECPD_FORM_RESET 2'h0
`define ECPD_DIV_RESET 16'h0800
`define ECPD_LINES_RESET 16'h0800
`define ECPD_ERR_RESET 20'h00000

// divider figures
`define ECPD_QUAD_MODULUS 17'h10000
`define ECPD_ENC13_PPR_CAP 16'h0800
`define ECPD_DIV_PASS 16'h0000

// error counter steps
`define ECPD_ERR_PLUS1 20'h00001
`define ECPD_ERR_MINUS1 20'hfffff
`define ECPD_ERR_ZERO 20'h00000

`endif

// File: include/ecpd_pkg.sv
// types for the error clear and pulse divider block
// assumes: nothing; every use is written with the package name
package ecpd_pkg;

  typedef enum logic [1:0] {
    ECPD_FORM_HIGH = 2'h0,
    ECPD_FORM_RISE = 2'h1,
    ECPD_FORM_LOW = 2'h2,
    ECPD_FORM_FALL = 2'h3
  } ecpd_form_t;

  // output quadrature state, named by {a,b}
  typedef enum logic [3:0] {
    ECPD_PH_00 = 4'h1,
    ECPD_PH_10 = 4'h2,
    ECPD_PH_11 = 4'h4,
    ECPD_PH_01 = 4'h8
  } ecpd_phase_t;

endpackage

// File: verilog/ecpd_sync.sv
// two flip-flop synchroniser, one per bit
// assumes: inputs are asynchronous to clk
module ecpd_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end
    else
    begin
      stage1_ff <= d;
      stage2_ff <= stage1_ff;
    end
  end

  assign q = stage2_ff;

endmodule

// File: verilog/ecpd_clear_ctl.sv
// error counter clear qualifier: level and edge forms
// assumes: clr_level already synchronised to clk
`include "ecpd_regs.svh"
module ecpd_clear_ctl (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs
  input wire logic clr_level,
  input wire logic [1:0] form_sel,
  // result
  output logic clearing
);

  ecpd_pkg::ecpd_form_t form_ff;
  ecpd_pkg::ecpd_form_t nxt_form;
  logic prev_ff;

  assign nxt_form = ecpd_pkg::ecpd_form_t'(form_sel);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      form_ff <= ecpd_pkg::ecpd_form_t'(`ECPD_FORM_RESET);
      prev_ff <= 1'b0;
    end
    else
    begin
      form_ff <= nxt_form;
      prev_ff <= clr_level;
    end
  end

  wire rise = clr_level & ~prev_ff;
  wire fall = ~clr_level & prev_ff;
  wire sel_high = (form_ff == ecpd_pkg::ECPD_FORM_HIGH);
  wire sel_rise = (form_ff == ecpd_pkg::ECPD_FORM_RISE);
  wire sel_low = (form_ff == ecpd_pkg::ECPD_FORM_LOW);
  wire sel_fall = (form_ff == ecpd_pkg::ECPD_FORM_FALL);

  wire clr_hold_high = sel_high & clr_level;
  wire clr_once_rise = sel_rise & rise;
  wire clr_hold_low = sel_low & ~clr_level;
  wire clr_once_fall = sel_fall & fall;

  assign clearing = clr_hold_high | clr_once_rise | clr_hold_low |
                    clr_once_fall;

endmodule

// File: verification/ecpd_top_props.sv
// concurrent checks on the ports of ecpd_top
// assumes: bound to ecpd_top; one clock, reset active high
module ecpd_top_props (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // inputs
  input wire logic [1:0] CLEAR_FORM_SELECT,
  input wire logic COUNTER_CLEAR_INPUT,
  input wire logic ENC_PHASE_A,
  input wire logic ENC_PHASE_B,
  input wire logic ENC_PHASE_Z,
  // outputs
  input wire logic [19:0] POSITION_ERROR,
  input wire logic POSITION_LOOP_ENABLE,
  input wire logic ENCODER_FAULT,
  input wire logic DIVIDED_PHASE_A_OUT,
  input wire logic DIVIDED_PHASE_A_OUT_N,
  input wire logic DIVIDED_PHASE_B_OUT,
  input wire logic DIVIDED_PHASE_B_OUT_N,
  input wire logic DIVIDED_INDEX_OUT,
  input wire logic DIVIDED_INDEX_OUT_N
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [1:0] fs = CLEAR_FORM_SELECT;
  wire logic pin = COUNTER_CLEAR_INPUT;
  wire logic le = POSITION_LOOP_ENABLE;
  wire logic zero = POSITION_ERROR == 20'h00000;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  // one cleared cycle framed by running cycles
  sequence once_clr;
    le ##1 (!le && zero) ##1 le;
  endsequence
  AST_A_PAIR:
    assert property (DIVIDED_PHASE_A_OUT_N != DIVIDED_PHASE_A_OUT)
    else $error("phase a pair not complementary");
  AST_BC_PAIR:
    assert property ((DIVIDED_PHASE_B_OUT_N != DIVIDED_PHASE_B_OUT) &&
      (DIVIDED_INDEX_OUT_N != DIVIDED_INDEX_OUT))
    else $error("phase b or c pair not complementary");
  AST_CLR_ZERO:
    assert property (!le |-> zero)
    else $error("loop held off with nonzero error");
  AST_FORM0:
    assert property ((fs == 2'h0 && pin) [*6] |-> !le && zero)
    else $error("high level did not hold clear");
  AST_FORM2:
    assert property ((fs == 2'h2 && !pin) [*6] |-> !le && zero)
    else $error("low level did not hold clear");
  AST_FORM1:
    assert property ((fs == 2'h1 && !pin) [*2] ##1 (fs == 2'h1 && pin)
      |-> ##[2:5] once_clr)
    else $error("rising edge did not clear once");
  AST_FORM3:
    assert property ((fs == 2'h3 && pin) [*2] ##1 (fs == 2'h3 && !pin)
      |-> ##[2:5] once_clr)
    else $error("falling edge did not clear once");
  AST_QUAD:
    assert property (!($changed(DIVIDED_PHASE_A_OUT) &&
      $changed(DIVIDED_PHASE_B_OUT)))
    else $error("both output phases moved together");
  AST_INDEX:
    assert property ($rose(ENC_PHASE_Z) ##1 ENC_PHASE_Z [*4]
      |-> DIVIDED_INDEX_OUT)
    else $error("index not passed to output");
  AST_FAULT:
    assert property (($changed(ENC_PHASE_A) && $changed(ENC_PHASE_B)) ##1
      ($stable(ENC_PHASE_A) && $stable(ENC_PHASE_B)) [*4] |-> ENCODER_FAULT)
    else $error("double phase change not flagged");
  COV_ONCE: cover property (once_clr);
  COV_HOLD: cover property (!le [*6]);
  COV_FAULT: cover property ($rose(ENCODER_FAULT));
  COV_INDEX: cover property ($rose(DIVIDED_INDEX_OUT));
endmodule

bind ecpd_top ecpd_top_props ecpd_top_props_i (
  .CLK_SYS(CLK_SYS), .RST(RST), .CLEAR_FORM_SELECT(CLEAR_FORM_SELECT),
  .COUNTER_CLEAR_INPUT(COUNTER_CLEAR_INPUT), .ENC_PHASE_A(ENC_PHASE_A),
  .ENC_PHASE_B(ENC_PHASE_B), .ENC_PHASE_Z(ENC_PHASE_Z),
  .POSITION_ERROR(POSITION_ERROR),
  .POSITION_LOOP_ENABLE(POSITION_LOOP_ENABLE),
  .ENCODER_FAULT(ENCODER_FAULT), .DIVIDED_PHASE_A_OUT(DIVIDED_PHASE_A_OUT),
  .DIVIDED_PHASE_A_OUT_N(DIVIDED_PHASE_A_OUT_N),
  .DIVIDED_PHASE_B_OUT(DIVIDED_PHASE_B_OUT),
  .DIVIDED_PHASE_B_OUT_N(DIVIDED_PHASE_B_OUT_N),
  .DIVIDED_INDEX_OUT(DIVIDED_INDEX_OUT),
  .DIVIDED_INDEX_OUT_N(DIVIDED_INDEX_OUT_N)
);

// File: verification/ecpd_host_model.sv
// host controller model counting the divided outputs
// assumes: outputs registered on clk; a leading b means forward
module ecpd_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // divided outputs
  input wire logic a,
  input wire logic b,
  input wire logic c,
  // counts
  output int steps,
  output int marks
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pa_ff;
  logic pb_ff;
  logic pc_ff;
  wire logic moved = (a ^ pa_ff) | (b ^ pb_ff);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pa_ff <= 1'b0;
      pb_ff <= 1'b0;
      pc_ff <= 1'b0;
      steps <= 0;
      marks <= 0;
    end
    else
    begin
      pa_ff <= a;
      pb_ff <= b;
      pc_ff <= c;
      if (moved)
        steps <= (pa_ff ^ b) ? steps - 1 : steps + 1;
      if (c && !pc_ff)
        marks <= marks + 1;
    end
  end
endmodule

// File: verification/ecpd_top_tb.sv
// self-checking bench for ecpd_top
// assumes: checker bound in its own file; host model counts outputs
module ecpd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [1:0] f;
    logic p;
    logic up;
    int n;
    int k;
  } ecpd_row_t;
  logic clk_sys, rst, clr, ra, rb, rz, step, up, ser, b13;
  logic loop_en, fault, pa, pa_n, pb, pb_n, pc, pc_n;
  logic [1:0] form;
  logic [15:0] div, lines;
  logic [19:0] perr, exp_err, dlt;
  int steps, marks, miscompares, compares, epos;
  logic [1:0] gtab [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
  // k: 0 counts on, 1 held cleared, 2 cleared once then counts
  ecpd_row_t rows [9] = '{'{2'h0, 1, 1, 3, 1}, '{2'h0, 0, 1, 3, 0},
    '{2'h2, 0, 1, 3, 1}, '{2'h2, 1, 0, 2, 0}, '{2'h1, 1, 1, 4, 0},
    '{2'h1, 0, 0, 5, 0}, '{2'h1, 1, 1, 2, 2}, '{2'h3, 1, 0, 1, 0},
    '{2'h3, 0, 0, 1, 2}};
  ecpd_top ecpd_top_i (
    .CLK_SYS(clk_sys), .RST(rst), .CLEAR_FORM_SELECT(form),
    .OUTPUT_PULSE_DIVIDER(div), .SOURCE_ENCODER_LINE_COUNT(lines),
    .ENCODER_IS_SERIAL(ser), .ENCODER_13BIT(b13), .COUNTER_CLEAR_INPUT(clr),
    .ENC_PHASE_A(ra), .ENC_PHASE_B(rb), .ENC_PHASE_Z(rz), .REF_STEP(step),
    .REF_DIR_UP(up), .POSITION_ERROR(perr), .POSITION_LOOP_ENABLE(loop_en),
    .ENCODER_FAULT(fault), .DIVIDED_PHASE_A_OUT(pa),
    .DIVIDED_PHASE_A_OUT_N(pa_n), .DIVIDED_PHASE_B_OUT(pb),
    .DIVIDED_PHASE_B_OUT_N(pb_n), .DIVIDED_INDEX_OUT(pc),
    .DIVIDED_INDEX_OUT_N(pc_n));
  ecpd_host_model ecpd_host_model_i (.clk(clk_sys), .rst(rst), .a(pa),
    .b(pb), .c(pc), .steps(steps), .marks(marks));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////
  task automatic tick(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chkv(string nm, logic [19:0] e, logic [19:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkn(string nm, int e, int g);
    compares++;
    if (g != e)
    begin
      miscompares++;
      $display("unexpected %s: expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset(logic [15:0] d, logic [15:0] l, logic s, logic t);
    tick(1);
    div = d;
    lines = l;
    ser = s;
    b13 = t;
    rst = 1'b1;
    tick(3);
    rst = 1'b0;
    tick(1);
    chkv("loop after reset", 20'h00001, 20'(loop_en));
    tick(3);
    div = 16'h0001;
  endtask
  task automatic ref_steps(int n, logic u);
    repeat (n)
    begin
      step = 1'b1;
      up = u;
      tick(1);
      step = 1'b0;
      tick(1);
    end
  endtask
  task automatic enc(int n, logic fwd);
    repeat (n)
    begin
      epos = fwd ? epos + 1 : epos - 1;
      {ra, rb} = gtab[epos & 3];
      tick(4);
    end
  endtask
  task automatic enc_case(logic [15:0] d, logic [15:0] l, logic s,
    logic t, int n, int e);
    do_reset(d, l, s, t);
    enc(n, 1'b1);
    tick(6);
    chkn("output steps", e, steps);
    chkv("position error", 20'h00000 - 20'(n), perr);
    chkv("fault", 20'h00000, 20'(fault));
    $display("divider case of %0d counts done", n);
  endtask
  ////////////////////////////////////////
  initial
  begin
    {rst, clr, ra, rb, rz, step, up, ser, b13} = 9'h100;
    form = 2'h0;
    div = 16'h0800;
    lines = 16'h0800;
    epos = 0;
    exp_err = 20'h00000;
    do_reset(16'h0800, 16'h0800, 1'b0, 1'b0);
    foreach (rows[i])
    begin
      form = rows[i].f;
      clr = rows[i].p;
      tick(8);
      ref_steps(rows[i].n, rows[i].up);
      tick(4);
      dlt = 20'(rows[i].n);
      if (rows[i].k != 0)
        exp_err = 20'h00000;
      if (rows[i].k != 1)
        exp_err = rows[i].up ? exp_err + dlt : exp_err - dlt;
      chkv("position error", exp_err, perr);
      chkv("loop enable", 20'(rows[i].k != 1), 20'(loop_en));
      $display("clear row %0d done", i);
    end
    form = 2'h0;
    clr = 1'b0;
    enc_case(16'h0000, 16'h0800, 1'b0, 1'b0, 8, 8);
    enc(4, 1'b0);
    tick(6);
    chkn("output steps", 4, steps);
    chkv("position error", 20'hffffc, perr);
    rz = 1'b1;
    tick(6);
    rz = 1'b0;
    tick(6);
    chkn("index marks", 1, marks);
    epos = epos + 2;
    {ra, rb} = gtab[epos & 3];
    tick(8);
    chkv("fault", 20'h00001, 20'(fault));
    do_reset(16'h0000, 16'h0800, 1'b0, 1'b0);
    tick(4);
    chkv("fault after reset", 20'h00000, 20'(fault));
    chkv("error after reset", 20'h00000, perr);
    chkn("steps after reset", 0, steps);
    epos = 0;
    {ra, rb} = 2'b00;
    $display("direction, index and fault done");
    enc_case(16'h4000, 16'h0800, 1'b0, 1'b0, 16, 4);
    enc(16, 1'b0);
    tick(6);
    chkn("output steps back", 0, steps);
    chkv("position error back", 20'h00000, perr);
    $display("reverse divider case done");
    enc_case(16'h8000, 16'h0800, 1'b0, 1'b1, 64, 2);
    enc_case(16'h0200, 16'h0400, 1'b1, 1'b0, 16, 8);
    tick(1);
    rst = 1'b1;
    tick(1);
    chkv("error at reset", 20'h00000, perr);
    chkv("pins at reset", 20'h00015,
      20'({loop_en, fault, pa, pa_n, pb, pb_n, pc, pc_n}));
    $display("reset test done");
    end_sim;
  end
  initial
  begin
    #(40 * 20000);
    miscompares++;
    $display("watchdog expired");
    end_sim;
  end
endmodule
